// ### hw/dvs_consts.svh
// named constants for the voltage-scaling register slave
// assumes a 20 MHz core clock; included by bare name from hw/
`ifndef DVS_CONSTS_SVH
`define DVS_CONSTS_SVH

// register indices (two low bits of the register address byte)
`define REG_FLOOR 2'h0
`define REG_ROOF 2'h1
`define REG_STYLE 2'h2
`define REG_RAMP 2'h3
`define REG_INDEX_TOP 6'h00

// slave address: fixed nibble, factory option pair, fixed low bit
`define ADDR_FIXED 4'h9
`define ADDR_OPTION 2'h0
`define ADDR_LSB 1'h0
`define HS_CODE_TOP 5'h01

// value read back from an unmapped register index
`define UNDEF_READ 8'h00

// reset values; the level code default is arbitrary
`define LEVEL_CODE_RESET 6'h20
`define ON_BIT_RESET 1'h1
`define SPARE_RESET 1'h0
`define STYLE_RESET 8'h00
`define DISCHARGE_RESET 1'h1
`define RATE_IMMEDIATE 3'h7

// operating style override field
`define MODE_CTRL_FOLLOW 2'h0
`define MODE_CTRL_FORCED 2'h2

// serial framing
`define BYTE_BITS 4'h8

// ramp timing: one micro-step is 12.5 mV, slowest slew 0.15 mV/us
`define CLK_NS 50
`define STEP_UV 12500
`define SLOWEST_RATE_UV_PER_US 150
`define SLOWEST_STEP_CYCLES \
	((`STEP_UV * 1000 + `SLOWEST_RATE_UV_PER_US * `CLK_NS - 1) / \
	(`SLOWEST_RATE_UV_PER_US * `CLK_NS))
`define STEP_TIMER_W 12

`endif

// ### hw/dvs_pkg.sv
// types shared by the register slave and its ramp generator
// assumes nothing beyond a SystemVerilog compiler
package dvs_pkg;

	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_ADDR = 9'h002,
		ST_ADDR_ACK = 9'h004,
		ST_REG = 9'h008,
		ST_REG_ACK = 9'h010,
		ST_WDATA = 9'h020,
		ST_WDATA_ACK = 9'h040,
		ST_RDATA = 9'h080,
		ST_RDATA_ACK = 9'h100
	} serial_state_e;

	typedef struct packed {
		logic converter_on_bit;
		logic spare;
		logic [5:0] code;
	} level_reg_s;

	typedef struct packed {
		logic [1:0] reserved;
		logic [1:0] spare;
		logic [1:0] mode_ctrl;
		logic roof_style_bit;
		logic floor_style_bit;
	} style_reg_s;

	typedef struct packed {
		logic spare_hi;
		logic discharge;
		logic power_good_flag;
		logic [1:0] spare_lo;
		logic [2:0] ramp_rate_field;
	} ramp_reg_s;

	typedef struct packed {
		logic [5:0] code;
		logic [2:0] ramp_rate_field;
		logic forced_pwm;
	} target_s;

endpackage

// ### hw/dvs_ramp.sv
// output level ramp generator: walks the level code toward its target
// assumes the target is steady logic on clk, not a raw pin
`timescale 1ns/1ns
`default_nettype none
`include "dvs_consts.svh"

module dvs_ramp (
	input wire logic clk,
	input wire logic rst_n,
	input wire dvs_pkg::target_s target,
	output logic [5:0] level_code,
	output logic ramping,
	output logic coast_start
);
	import dvs_pkg::*;

	logic [`STEP_TIMER_W-1:0] step_timer;
	logic [`STEP_TIMER_W-1:0] step_interval;
	logic immediate;
	logic going_down;
	logic moving;

	// slew codes double from 000 upward, so the interval halves per code
	always_comb begin
		immediate = (target.ramp_rate_field == `RATE_IMMEDIATE);
		going_down = (target.code < level_code);
		moving = (target.code != level_code);
		step_interval = `STEP_TIMER_W'(`SLOWEST_STEP_CYCLES >>
			target.ramp_rate_field);
	end

	// level tracking; a new target mid-ramp simply redirects the walk
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			level_code <= `LEVEL_CODE_RESET;
			step_timer <= '0;
		end else if (!moving) begin
			step_timer <= '0;
		end else if (immediate) begin
			level_code <= target.code;
			step_timer <= '0;
		end else if (step_timer >= step_interval - `STEP_TIMER_W'(1)) begin
			step_timer <= '0;
			level_code <= going_down ? level_code - 6'h01
				: level_code + 6'h01;
		end else begin
			step_timer <= step_timer + `STEP_TIMER_W'(1);
		end
	end

	// status toward power-good: stepped walks and uncontrolled decays
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ramping <= 1'b0;
			coast_start <= 1'b0;
		end else begin
			ramping <= moving && !immediate;
			// auto mode stops switching and lets the load pull it down
			coast_start <= moving && immediate && going_down
				&& !target.forced_pwm;
		end
	end

endmodule
`default_nettype wire

// ### hw/dvs_i2c_register_slave.sv
// serial register slave and level control of a step-down converter
// assumes open-drain data with an outside pull-up; all pins are async
//
// What this block does
// - pulse-skip level-select fall keeps power-good low until pulsing resumes
// - stepped ramping keeps power-good low while the output ramps
// - ramp code 111 raises the output at maximum slew
// - code 111 downward: immediate if forced PWM, else stop switching
// - codes 000-110 time the interval between micro-steps
// - slave only, standard through high-speed bit rates
// - 7-bit addressing only; 10-bit and general call ignored
// - address is 1001, two option bits, then zero
// - acknowledge only a matching address, low through ninth clock high
// - acknowledge every byte received in a write
// - start, address, register byte, data; commit on last bit's fall
// - register byte upper six bits zero, low two pick a register
// - unmapped register reads return 00h
// - high-speed unmapped reads also return 00h
// - master code 00001XXX is not acknowledged but enters high speed
// - stop leaves high speed; repeated starts keep it
// - start is data falling with clock high, stop data rising
// - enable pin low blocks updates; register enable bit does not
// - floor bit 7 gates the enable pin and mirrors roof bit 7
// - floor code is a 6-bit linear level in bits 5 to 0
// - level-select low uses floor code and style, high the roof's
// - writing the selected level moves the output; the other does not
// - enable pin rising edge restores all registers to defaults
// - ramp codes double in slew from 000 to 110; 111 is immediate
`timescale 1ns/1ns
`default_nettype none
`include "dvs_consts.svh"

module dvs_i2c_register_slave (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scl_pin,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic en_pin,
	input wire logic level_select_pin,
	input wire logic in_regulation,
	input wire logic pulsing_resumed,
	output logic [5:0] level_code,
	output logic forced_pwm,
	output logic converter_active,
	output logic discharge_active,
	output logic power_good_flag,
	output logic hs_mode
);
	import dvs_pkg::*;

	// pin synchronisers: meta is read only by sync
	logic [5:0] pin_meta;
	logic [5:0] pin_sync;
	logic [5:0] pin_prev;
	logic scl_s;
	logic sda_s;
	logic en_s;
	logic sel_s;
	logic reg_ok_s;
	logic pulsing_s;
	logic scl_q;
	logic sda_q;
	logic en_q;
	logic sel_q;

	// bus framing
	logic start_cond;
	logic stop_cond;
	logic scl_rise;
	logic scl_fall;
	logic en_rise;
	logic byte_done;
	serial_state_e state;
	logic [3:0] bit_count;
	logic [7:0] rx_shift;
	logic [7:0] tx_shift;
	logic [7:0] reg_pointer;
	logic read_dir;
	logic master_ack;
	logic addr_match;
	logic hs_code;
	logic write_commit;
	logic [7:0] read_value;

	// register file and control state
	level_reg_s floor_level_register;
	level_reg_s roof_level_register;
	style_reg_s operating_style_register;
	ramp_reg_s ramp_and_discharge_register;
	target_s target;
	logic auto_style;
	logic converter_on;
	logic ramping;
	logic coast_start;
	logic decaying;

	// bus and enable idle high, status pins idle low: no false edge or
	// power-good blip just after reset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pin_meta <= 6'h3C;
			pin_sync <= 6'h3C;
			pin_prev <= 6'h3C;
		end else begin
			pin_meta <= {scl_pin, sda_in, en_pin, level_select_pin,
				in_regulation, pulsing_resumed};
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	// named views of synchronised pins and their previous samples
	assign {scl_s, sda_s, en_s, sel_s, reg_ok_s, pulsing_s} = pin_sync;
	assign {scl_q, sda_q, en_q, sel_q} = pin_prev[5:2];

	// edges of the sampled bus; clock high on both samples guards
	// against reading a data change as a condition
	assign start_cond = scl_s && scl_q && sda_q && !sda_s;
	assign stop_cond = scl_s && scl_q && !sda_q && sda_s;
	assign scl_rise = scl_s && !scl_q;
	assign scl_fall = !scl_s && scl_q;
	assign en_rise = en_s && !en_q;
	assign byte_done = scl_fall && (bit_count == `BYTE_BITS);

	// only 7-bit addresses match; general call and 10-bit heads fall out
	assign addr_match = (rx_shift[7:1] ==
		{`ADDR_FIXED, `ADDR_OPTION, `ADDR_LSB});
	assign hs_code = (rx_shift[7:3] == `HS_CODE_TOP);
	assign write_commit = (state == ST_WDATA) && byte_done;

	// read mux; unmapped indices give the same value at every speed
	function automatic logic [7:0] read_byte(input logic [7:0] idx);
		logic [7:0] value;
		value = `UNDEF_READ;
		if (idx[7:2] == `REG_INDEX_TOP) begin
			unique case (idx[1:0])
				`REG_FLOOR: value = floor_level_register;
				`REG_ROOF: value = roof_level_register;
				`REG_STYLE: value = operating_style_register;
				`REG_RAMP: begin
					value = ramp_and_discharge_register;
					value[5] = power_good_flag;
				end
			endcase
		end
		return value;
	endfunction
	assign read_value = read_byte(reg_pointer);

	// bit sampler: data is taken on the rising clock edge
	always_ff @(posedge clk) begin
		if (!rst_n || start_cond) begin
			bit_count <= 4'h0;
			rx_shift <= 8'h00;
		end else if (scl_fall && state != ST_ADDR && state != ST_REG
			&& state != ST_WDATA && state != ST_RDATA) begin
			bit_count <= 4'h0;
		end else if (scl_rise && bit_count != `BYTE_BITS) begin
			bit_count <= bit_count + 4'h1;
			rx_shift <= {rx_shift[6:0], sda_s};
		end else if (byte_done) begin
			bit_count <= 4'h0;
		end
	end

	// transfer sequencer; data out changes only while the clock is low.
	// sampling at 20 MHz leaves few samples per high-speed bit, so the
	// bus must respect its minimum high and low times
	always_ff @(posedge clk) begin
		if (!rst_n || !en_s || stop_cond) begin
			state <= ST_IDLE;
			sda_oe <= 1'b0;
			read_dir <= 1'b0;
			master_ack <= 1'b0;
			tx_shift <= 8'h00;
		end else if (start_cond) begin
			state <= ST_ADDR;
			sda_oe <= 1'b0;
		end else begin
			unique case (state)
				ST_IDLE: ;
				ST_ADDR: begin
					if (byte_done && addr_match) begin
						sda_oe <= 1'b1;
						read_dir <= rx_shift[0];
						state <= ST_ADDR_ACK;
					end else if (byte_done) begin
						state <= ST_IDLE;
					end
				end
				ST_ADDR_ACK: begin
					if (scl_fall && read_dir) begin
						tx_shift <= read_value << 1;
						sda_oe <= !read_value[7];
						state <= ST_RDATA;
					end else if (scl_fall) begin
						sda_oe <= 1'b0;
						state <= ST_REG;
					end
				end
				ST_REG: begin
					if (byte_done) begin
						sda_oe <= 1'b1;
						state <= ST_REG_ACK;
					end
				end
				ST_REG_ACK: begin
					if (scl_fall) begin
						sda_oe <= 1'b0;
						state <= ST_WDATA;
					end
				end
				ST_WDATA: begin
					if (byte_done) begin
						sda_oe <= 1'b1;
						state <= ST_WDATA_ACK;
					end
				end
				ST_WDATA_ACK: begin
					if (scl_fall) begin
						sda_oe <= 1'b0;
						state <= ST_WDATA;
					end
				end
				ST_RDATA: begin
					if (byte_done) begin
						sda_oe <= 1'b0;
						state <= ST_RDATA_ACK;
					end else if (scl_fall) begin
						sda_oe <= !tx_shift[7];
						tx_shift <= tx_shift << 1;
					end
				end
				ST_RDATA_ACK: begin
					if (scl_rise) begin
						master_ack <= !sda_s;
					end else if (scl_fall && master_ack) begin
						tx_shift <= read_value << 1;
						sda_oe <= !read_value[7];
						state <= ST_RDATA;
					end else if (scl_fall) begin
						state <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// register pointer: set by the register byte, advanced per data byte
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reg_pointer <= 8'h00;
		end else if (state == ST_REG && byte_done) begin
			reg_pointer <= rx_shift;
		end else if (write_commit) begin
			reg_pointer <= reg_pointer + 8'h01;
		end else if (state == ST_RDATA && byte_done) begin
			reg_pointer <= reg_pointer + 8'h01;
		end
	end

	// open-drain: only ever pulls low, the enable carries the bit
	always_ff @(posedge clk) begin
		sda_out <= 1'b0;
	end

	// high-speed flag: set by the master code, dropped at stop
	always_ff @(posedge clk) begin
		if (!rst_n || !en_s || stop_cond) begin
			hs_mode <= 1'b0;
		end else if (state == ST_ADDR && byte_done && hs_code) begin
			hs_mode <= 1'b1;
		end
	end

	// register file; the enable pin's rising edge restores defaults,
	// while the enable bit itself leaves the contents alone
	always_ff @(posedge clk) begin
		if (!rst_n || en_rise) begin
			floor_level_register <= {`ON_BIT_RESET, `SPARE_RESET,
				`LEVEL_CODE_RESET};
			roof_level_register <= {`ON_BIT_RESET, `SPARE_RESET,
				`LEVEL_CODE_RESET};
			operating_style_register <= `STYLE_RESET;
			ramp_and_discharge_register <= {`SPARE_RESET,
				`DISCHARGE_RESET, 1'b0, 2'b00, `RATE_IMMEDIATE};
		end else if (write_commit && reg_pointer[7:2] == `REG_INDEX_TOP)
		begin
			unique case (reg_pointer[1:0])
				`REG_FLOOR: begin
					floor_level_register <= rx_shift;
					roof_level_register.converter_on_bit <=
						rx_shift[7];
				end
				`REG_ROOF: begin
					roof_level_register <= rx_shift;
					floor_level_register.converter_on_bit <=
						rx_shift[7];
				end
				`REG_STYLE: begin
					// the two top bits are reserved and stay zero
					operating_style_register[5:0] <= rx_shift[5:0];
				end
				`REG_RAMP: begin
					// the power-good bit reads live state, not storage
					ramp_and_discharge_register <= {rx_shift[7:6], 1'b0,
						rx_shift[4:0]};
				end
			endcase
		end
	end

	// target selection by level-select; the unselected register is
	// held in storage only, so writing it leaves the output alone
	always_comb begin
		unique case (operating_style_register.mode_ctrl)
			`MODE_CTRL_FOLLOW: auto_style = sel_s ?
				operating_style_register.roof_style_bit
				: operating_style_register.floor_style_bit;
			`MODE_CTRL_FORCED: auto_style = 1'b0;
			default: auto_style = 1'b1;
		endcase
		target.code = sel_s ? roof_level_register.code
			: floor_level_register.code;
		target.ramp_rate_field =
			ramp_and_discharge_register.ramp_rate_field;
		target.forced_pwm = !auto_style;
	end

	assign converter_on = en_s && floor_level_register.converter_on_bit;

	dvs_ramp ramp_gen (
		.clk(clk),
		.rst_n(rst_n),
		.target(target),
		.level_code(level_code),
		.ramping(ramping),
		.coast_start(coast_start)
	);

	// decay tracking: a new start wins over the clearing pulse input
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			decaying <= 1'b0;
		end else if (coast_start || (sel_q && !sel_s && auto_style)) begin
			decaying <= 1'b1;
		end else if (pulsing_s) begin
			decaying <= 1'b0;
		end
	end

	// converter-facing outputs, all registered
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			forced_pwm <= 1'b0;
			converter_active <= 1'b0;
			discharge_active <= 1'b0;
			power_good_flag <= 1'b0;
		end else begin
			forced_pwm <= target.forced_pwm;
			converter_active <= converter_on;
			discharge_active <= !converter_on &&
				ramp_and_discharge_register.discharge;
			// held low across ramps and uncontrolled decays
			power_good_flag <= converter_on && reg_ok_s && !ramping
				&& !decaying && !coast_start;
		end
	end

endmodule
`default_nettype wire

// ### test/dvs_slave_checker_assertions.sv
// checker: pin-level relations of the register slave
// assumes one clock domain and a bench bit time of eight clocks
`timescale 1ns/1ns
`default_nettype none

module dvs_slave_checker (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scl_pin,
	input wire logic sda_in,
	input wire logic sda_oe,
	input wire logic en_pin,
	input wire logic in_regulation,
	input wire logic converter_active,
	input wire logic power_good_flag,
	input wire logic hs_mode
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// enable gating and status flags
	en_block_a: assert property (!en_pin [*8] |-> !sda_oe)
		else $error("data pulled while disabled");
	en_gate_a: assert property (!en_pin [*4] |-> !converter_active)
		else $error("converter on with pin low");
	pg_reg_a: assert property (!in_regulation [*4] |-> !power_good_flag)
		else $error("power good out of regulation");

	// bus framing: slave changes data only with the clock low
	start_quiet_a: assert property (scl_pin && $fell(sda_in) |-> !sda_oe [*8])
		else $error("data pulled after start");
	drive_len_a: assert property ($rose(sda_oe) |-> sda_oe [*8])
		else $error("drive shorter than a bit");
	scl_high_a: assert property (scl_pin && $past(scl_pin) |-> $stable(sda_oe))
		else $error("data moved with clock high");
	hs_quiet_a: assert property ($rose(hs_mode) |-> !sda_oe [*8])
		else $error("master code answered");
	stop_hs_a: assert property (scl_pin && $past(scl_pin) && $rose(sda_in) |-> ##[1:6] !hs_mode)
		else $error("high speed kept after stop");
endmodule

bind dvs_i2c_register_slave dvs_slave_checker chk_i (.clk, .rst_n, .scl_pin,
	.sda_in, .sda_oe, .en_pin, .in_regulation, .converter_active,
	.power_good_flag, .hs_mode);
`default_nettype wire

// ### test/i2c_master_model.sv
// bus master model: clock line and open-drain data line
// assumes a pull-up on data; a bit takes four quarters of qlen clocks
`timescale 1ns/1ns
`default_nettype none

module i2c_master_model (
	input wire logic clk,
	input wire logic sda_line,
	output logic scl,
	output logic sda_o
);
	int qlen = 2;
	initial begin
		scl = 1'b1;
		sda_o = 1'b1;
	end
	// quarter bit; slowed by the bench for the master code
	task q;
		repeat (qlen) @(posedge clk);
	endtask
	// start, or repeated start from clock low
	task start;
		sda_o <= 1'b1;
		q;
		scl <= 1'b1;
		q;
		sda_o <= 1'b0;
		q;
		scl <= 1'b0;
		q;
	endtask
	task stop;
		sda_o <= 1'b0;
		q;
		scl <= 1'b1;
		q;
		sda_o <= 1'b1;
		q;
	endtask
	// data only moves while the clock is low
	task bit_io(input logic b, output logic r);
		sda_o <= b;
		q;
		scl <= 1'b1;
		q;
		r = sda_line;
		q;
		scl <= 1'b0;
		q;
	endtask
	task wb(input logic [7:0] v, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(v[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask
	task rb(input logic nack, output logic [7:0] v);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			v[i] = r;
		end
		bit_io(nack, r);
	endtask
endmodule
`default_nettype wire

// ### test/dvs_i2c_register_slave_tb.sv
// bench: register slave driven through the bus master model
// assumes the address option bits of the shared constants
`timescale 1ns/1ns
`default_nettype none
`include "dvs_consts.svh"

module dvs_i2c_register_slave_tb;
	localparam logic [7:0] sla_w = {`ADDR_FIXED, `ADDR_OPTION, `ADDR_LSB, 1'b0};
	localparam logic [7:0] defs [4] = '{8'hA0, 8'hA0, 8'h00, 8'h47};
	localparam logic [7:0] bad [4] = '{8'h00, 8'hF0, 8'h94, 8'h92};
	logic clk, rst_n, en_pin, level_select_pin, in_regulation;
	logic pulsing_resumed, scl, sda_m, sda_out, sda_oe, converter_active;
	logic discharge_active, forced_pwm, power_good_flag, hs_mode, k;
	logic [5:0] level_code;
	logic [7:0] d;
	wire logic sda;
	int mismatches, comparisons, cycles;
	// open-drain line with pull-up
	assign sda = sda_m & ~(sda_oe & ~sda_out);

	dvs_i2c_register_slave uut (.clk, .rst_n, .scl_pin(scl), .sda_in(sda),
		.sda_out, .sda_oe, .en_pin, .level_select_pin, .in_regulation,
		.pulsing_resumed, .level_code, .forced_pwm, .converter_active,
		.discharge_active, .power_good_flag, .hs_mode);
	i2c_master_model m (.clk, .sda_line(sda), .scl, .sda_o(sda_m));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// hang guard: the run needs about a tenth of this
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			mismatches++;
			report_and_stop;
		end
	end

	task w(input int n);
		repeat (n) @(posedge clk);
	endtask
	task chk(input string n, input logic [7:0] e, input logic [7:0] s);
		comparisons++;
		if (s !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] v, output logic ok);
		logic k1, k2, k3;
		m.start;
		m.wb(sla_w, k1);
		m.wb(a, k2);
		m.wb(v, k3);
		m.stop;
		ok = k1 & k2 & k3;
		w(2);
	endtask
	// pointer write, repeated start, one byte, nack, stop
	task rd(input logic [7:0] a, output logic [7:0] v);
		logic k1;
		m.start;
		m.wb(sla_w, k1);
		m.wb(a, k1);
		m.start;
		m.wb(sla_w | 8'h01, k1);
		m.rb(1'b1, v);
		m.stop;
		w(2);
	endtask

	task t_reset;
		for (int i = 0; i < 4; i++) begin
			rd(8'(i), d);
			chk("default", defs[i], d);
		end
		rd(8'h04, d);
		chk("index 4", `UNDEF_READ, d);
		rd(8'h41, d);
		chk("index 41", `UNDEF_READ, d);
		$display("reset test done");
	endtask
	task t_addr;
		for (int i = 0; i < 4; i++) begin
			m.start;
			m.wb(bad[i], k);
			m.stop;
			chk("foreign ack", 8'h00, 8'(k));
		end
		$display("address test done");
	endtask
	task t_write;
		wr(8'h01, 8'h95, k);
		chk("write ack", 8'h01, 8'(k));
		w(4);
		chk("roof level", 8'h15, 8'(level_code));
		wr(8'h00, 8'h8A, k);
		w(4);
		chk("floor hidden", 8'h15, 8'(level_code));
		rd(8'h00, d);
		chk("floor read", 8'h8A, d);
		$display("write test done");
	endtask
	// stepped ramp of two codes at the fastest stepped rate
	task t_ramp;
		in_regulation <= 1'b1;
		wr(8'h03, 8'h46, k);
		wr(8'h01, 8'h97, k);
		chk("pg ramping", 8'h00, 8'(power_good_flag));
		w(100);
		chk("ramp end", 8'h17, 8'(level_code));
		chk("pg settled", 8'h01, 8'(power_good_flag));
		$display("ramp test done");
	endtask
	task t_pfm;
		wr(8'h03, 8'h47, k);
		wr(8'h02, 8'h04, k);
		level_select_pin <= 1'b0;
		w(10);
		chk("floor applied", 8'h0A, 8'(level_code));
		chk("pg decay", 8'h00, 8'(power_good_flag));
		chk("auto style", 8'h00, 8'(forced_pwm));
		pulsing_resumed <= 1'b1;
		w(8);
		chk("pg resumed", 8'h01, 8'(power_good_flag));
		pulsing_resumed <= 1'b0;
		wr(8'h02, 8'h08, k);
		w(4);
		chk("forced style", 8'h01, 8'(forced_pwm));
		$display("style test done");
	endtask
	task t_hs;
		m.qlen = 13;
		m.start;
		m.wb(8'h08, k);
		chk("code ack", 8'h00, 8'(k));
		chk("hs entered", 8'h01, 8'(hs_mode));
		m.qlen = 2;
		m.start;
		m.wb(sla_w, k);
		m.wb(8'h05, k);
		m.start;
		m.wb(sla_w | 8'h01, k);
		m.rb(1'b1, d);
		chk("hs unmapped", `UNDEF_READ, d);
		chk("hs kept", 8'h01, 8'(hs_mode));
		m.stop;
		w(8);
		chk("hs left", 8'h00, 8'(hs_mode));
		$display("high speed test done");
	endtask
	task t_en;
		wr(8'h00, 8'h0A, k);
		w(4);
		chk("gate off", 8'h00, 8'(converter_active));
		chk("discharge", 8'h01, 8'(discharge_active));
		rd(8'h01, d);
		chk("mirror", 8'h17, d);
		en_pin <= 1'b0;
		w(10);
		wr(8'h01, 8'h80, k);
		chk("disabled ack", 8'h00, 8'(k));
		en_pin <= 1'b1;
		w(10);
		rd(8'h00, d);
		chk("enable reset", 8'hA0, d);
		chk("gate on", 8'h01, 8'(converter_active));
		$display("enable test done");
	endtask

	task report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// reset for two edges; the bus waits until the synchronisers fill
	initial begin
		rst_n = 1'b0;
		en_pin = 1'b1;
		level_select_pin = 1'b1;
		in_regulation = 1'b0;
		pulsing_resumed = 1'b0;
		w(2);
		rst_n <= 1'b1;
		w(4);
		t_reset;
		t_addr;
		t_write;
		t_ramp;
		t_pfm;
		t_hs;
		t_en;
		report_and_stop;
	end
endmodule
`default_nettype wire
